// *** design/hnc_pkg.sv ***
package hnc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] HNC_OFS_SYNC_SRC = 12'h300;
  localparam logic [11:0] HNC_OFS_SEL_A = 12'h301;
  localparam logic [11:0] HNC_OFS_SEL_B = 12'h302;
  localparam logic [11:0] HNC_OFS_BANK = 12'h303;
  localparam logic [11:0] HNC_OFS_RUN = 12'h308;
  localparam logic [11:0] HNC_OFS_TRIG = 12'h310;
  localparam logic [11:0] HNC_OFS_HOLD = 12'h320;
  localparam logic [11:0] HNC_OFS_RAMP = 12'h330;
  localparam logic [11:0] HNC_OFS_OPT = 12'h331;
  localparam logic [11:0] HNC_OFS_GAIN_A = 12'h332;
  localparam logic [11:0] HNC_OFS_GAIN_B = 12'h334;
  localparam logic [11:0] HNC_OFS_FREQ = 12'h400;
  localparam logic [11:0] HNC_OFS_PHASE = 12'h480;
  localparam logic [11:0] HNC_FREQ_BYTES = 12'h080;
  localparam logic [11:0] HNC_PHASE_BYTES = 12'h040;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int HNC_CHG_A_BIT = 4;
  localparam int HNC_CHG_B_BIT = 5;
  localparam int HNC_OPT_SUM_BIT = 0;
  localparam int HNC_OPT_DITH_BIT = 1;
  localparam logic [7:0] HNC_OPT_RST = 8'h02;
  localparam logic [15:0] HNC_GAIN_RST = 16'h0003;
  localparam logic [15:0] HNC_DITHER_BACKOFF = 16'h0010;
  localparam logic [16:0] HNC_GAIN_UNITY = 17'h10000;
  localparam int HNC_RAMP_SHIFT0 = 3;
  localparam logic [15:0] HNC_LFSR_SEED = 16'hace1;

  typedef enum logic [1:0] {
    HNC_BANK_SPLIT = 2'b00,
    HNC_BANK_JOINT = 2'b01,
    HNC_BANK_ONE = 2'b10,
    HNC_BANK_RSVD = 2'b11
  } hnc_bank_e;

  typedef enum logic [1:0] {
    HNC_SYNC_NOW = 2'b00,
    HNC_SYNC_REF = 2'b01,
    HNC_SYNC_STROBE = 2'b10,
    HNC_SYNC_RSVD = 2'b11
  } hnc_sync_e;

  typedef enum logic [1:0] {
    HNC_ST_IDLE = 2'b00,
    HNC_ST_WAIT_REF = 2'b01,
    HNC_ST_WAIT_STB = 2'b10
  } hnc_sync_st_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] sel;
    logic bank;
    logic strobe;
    logic sref;
    logic gate_a;
    logic gate_b;
  } hnc_pins_s;

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic dither_on;
    logic [16:0] gain;
    logic gate;
    logic [2:0] ramp;
    logic sync_clr;
  } hnc_tone_cfg_s;

  function automatic logic [11:0] hnc_ramp_len(input logic [2:0] code);
    hnc_ramp_len = (code == 3'h0) ? 12'h000 : 12'(12'h001 << (32'(code) + HNC_RAMP_SHIFT0));
  endfunction : hnc_ramp_len

endpackage : hnc_pkg

// *** design/hnc_tone_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module hnc_tone_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire hnc_pkg::hnc_tone_cfg_s cfg,
  output logic signed [15:0] amp
);
  import hnc_pkg::*;

  typedef struct packed {
    logic [31:0] acc;
    logic [15:0] lfsr;
    logic [11:0] ramp_cnt;
    logic signed [15:0] amp;
  } hnc_core_s;

  hnc_core_s q, d;
  logic [31:0] phase;
  logic [17:0] fold;
  logic signed [19:0] tri_v;
  logic signed [19:0] rnd;
  logic signed [15:0] smp;
  logic signed [32:0] gprod;
  logic signed [15:0] gained;
  logic signed [28:0] rprod;
  logic signed [28:0] rsh;
  logic [11:0] len;

  // ****************************************
  // Accumulator, shaping, gain and ramp
  // ****************************************
  always_comb begin
    d = q;
    phase = q.acc + {cfg.phase, 16'h0000};
    // Triangle keeps this cheap; headroom left for the gain stage
    fold = phase[30] ? ~phase[29:12] : phase[29:12];
    tri_v = phase[31] ? -$signed({2'b00, fold}) : $signed({2'b00, fold});
    rnd = tri_v + $signed({16'h0000, (cfg.dither_on ? q.lfsr[3:0] : 4'h8)});
    smp = rnd[19:4];
    gprod = smp * $signed({1'b0, cfg.gain});
    gained = gprod[31:16];
    len = hnc_ramp_len(cfg.ramp);
    rprod = gained * $signed({1'b0, q.ramp_cnt});
    rsh = rprod >>> (32'(cfg.ramp) + HNC_RAMP_SHIFT0);
    d.acc = cfg.sync_clr ? 32'h0000_0000 : q.acc + cfg.freq;
    d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
    if (q.ramp_cnt > len) begin
      d.ramp_cnt = len;
    end else if (cfg.gate && q.ramp_cnt < len) begin
      d.ramp_cnt = q.ramp_cnt + 12'h001;
    end else if (!cfg.gate && q.ramp_cnt != 12'h000) begin
      d.ramp_cnt = q.ramp_cnt - 12'h001;
    end
    if (cfg.ramp == 3'h0) begin
      d.amp = cfg.gate ? gained : 16'sh0000;
    end else begin
      d.amp = rsh[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '{acc: 32'h0000_0000, lfsr: HNC_LFSR_SEED, ramp_cnt: 12'h000, amp: 16'sh0000};
    end else if (ce) begin
      q <= d;
    end
  end

  assign amp = q.amp;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_acc_step;
    // Sampled reset keeps the run-bit release edge out of the check
    !srst && ce && !cfg.sync_clr |=> q.acc == $past(q.acc) + $past(cfg.freq);
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

  property p_ramp_up;
    !srst && ce && cfg.gate && q.ramp_cnt < len |=> q.ramp_cnt == $past(q.ramp_cnt) + 12'h001;
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("ramp did not advance");

  property p_hard_gate;
    ce && cfg.ramp == 3'h0 && !cfg.gate |=> q.amp == 16'sh0000;
  endproperty
  a_hard_gate: assert property (p_hard_gate) else $error("gated output not zero");

  property p_sync_clear;
    ce && cfg.sync_clr |=> q.acc == 32'h0000_0000;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear");

  property p_ramp_full;
    len != 12'h000 && q.ramp_cnt == len;
  endproperty
  c_ramp_full: cover property (p_ramp_full);

endmodule : hnc_tone_core
`default_nettype wire

// *** design/hnc_hop_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module hnc_hop_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire hnc_pkg::hnc_pins_s pins,
  input wire logic channel_dither_a,
  input wire logic channel_dither_b,
  input wire logic nco_src_a,
  input wire logic nco_src_b,
  output logic [4:0] hop_sel_a,
  output logic [4:0] hop_sel_b,
  output logic signed [15:0] tone_a,
  output logic signed [15:0] tone_b
);
  import hnc_pkg::*;

  typedef struct packed {
    hnc_sync_e sync_src;
    logic chg_a;
    logic chg_b;
    logic [4:0] sel_sw_a;
    logic [4:0] sel_sw_b;
    hnc_bank_e bank;
    logic run;
    logic trig;
    logic hold;
    logic [2:0] ramp;
    logic opt_sum;
    logic opt_dith;
    logic [15:0] gain_a;
    logic [15:0] gain_b;
    hnc_pins_s s1;
    hnc_pins_s s2;
    hnc_pins_s s3;
    hnc_pins_s flt;
    logic [4:0] pin_sel_a;
    logic [4:0] pin_sel_b;
    logic [4:0] act_sel_a;
    logic [4:0] act_sel_b;
    logic [31:0] freq_a;
    logic [31:0] freq_b;
    logic [15:0] ph_a;
    logic [15:0] ph_b;
    hnc_sync_st_e sync_st;
    logic sync_clr;
    logic [7:0] rdata;
    logic rvalid;
    logic signed [15:0] out_a;
    logic signed [15:0] out_b;
  } hnc_ctl_s;

  hnc_ctl_s q, d;
  logic [7:0] freq_mem [0:127];
  logic [7:0] phase_mem [0:63];
  logic [8:0] agree;
  logic strobe_rise;
  logic ref_rise;
  logic fire;
  logic [3:0] hop_val;
  logic hop_bank;
  logic in_freq;
  logic in_phase;
  logic signed [16:0] sum_w;
  logic signed [15:0] sum_sat;
  logic signed [15:0] amp_a;
  logic signed [15:0] amp_b;
  hnc_tone_cfg_s cfg_a;
  hnc_tone_cfg_s cfg_b;

  function automatic logic [31:0] freq_at(input logic [4:0] idx);
    freq_at = {freq_mem[{idx, 2'b11}], freq_mem[{idx, 2'b10}],
               freq_mem[{idx, 2'b01}], freq_mem[{idx, 2'b00}]};
  endfunction : freq_at

  function automatic logic [15:0] phase_at(input logic [4:0] idx);
    phase_at = {phase_mem[{idx, 1'b1}], phase_mem[{idx, 1'b0}]};
  endfunction : phase_at

  function automatic logic [16:0] gain_fac(input logic [15:0] g, input logic dith);
    logic [16:0] eff;
    eff = {1'b0, g} + (dith ? {1'b0, HNC_DITHER_BACKOFF} : 17'h00000);
    gain_fac = (eff >= HNC_GAIN_UNITY) ? 17'h00000 : HNC_GAIN_UNITY - eff;
  endfunction : gain_fac

  assign in_freq = reg_addr >= HNC_OFS_FREQ && reg_addr < HNC_OFS_FREQ + HNC_FREQ_BYTES;
  assign in_phase = reg_addr >= HNC_OFS_PHASE && reg_addr < HNC_OFS_PHASE + HNC_PHASE_BYTES;

  // ****************************************
  // Tables
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 128; i++) begin
        freq_mem[i] <= 8'h00;
      end
      for (int i = 0; i < 64; i++) begin
        phase_mem[i] <= 8'h00;
      end
    end else if (ce && reg_wr) begin
      if (in_freq) begin
        freq_mem[reg_addr[6:0]] <= reg_wdata;
      end
      if (in_phase) begin
        phase_mem[reg_addr[5:0]] <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Control logic
  // ****************************************
  always_comb begin
    d = q;
    fire = 1'b0;
    // Only the second and third stages are compared; first stage feeds nothing else
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    d.flt = hnc_pins_s'((agree & q.s3) | (~agree & q.flt));
    strobe_rise = d.flt.strobe & ~q.flt.strobe;
    ref_rise = d.flt.sref & ~q.flt.sref;
    hop_val = d.flt.sel;
    hop_bank = d.flt.bank;

    if (strobe_rise && q.run) begin
      case (q.bank)
        HNC_BANK_SPLIT: begin
          d.pin_sel_a = {1'b0, hop_val};
          d.pin_sel_b = {1'b1, hop_val};
        end
        HNC_BANK_JOINT: begin
          d.pin_sel_a = {hop_bank, hop_val};
          d.pin_sel_b = {hop_bank, hop_val};
        end
        HNC_BANK_ONE: begin
          if (hop_bank) begin
            d.pin_sel_b = {1'b1, hop_val};
          end else begin
            d.pin_sel_a = {1'b0, hop_val};
          end
        end
        default: begin
          // Reserved bank code leaves selections alone
        end
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        HNC_OFS_SYNC_SRC: begin
          d.sync_src = hnc_sync_e'(reg_wdata[1:0]);
          d.chg_a = reg_wdata[HNC_CHG_A_BIT];
          d.chg_b = reg_wdata[HNC_CHG_B_BIT];
        end
        HNC_OFS_SEL_A: d.sel_sw_a = reg_wdata[4:0];
        HNC_OFS_SEL_B: d.sel_sw_b = reg_wdata[4:0];
        HNC_OFS_BANK: d.bank = hnc_bank_e'(reg_wdata[1:0]);
        HNC_OFS_RUN: d.run = reg_wdata[0];
        HNC_OFS_TRIG: begin
          d.trig = reg_wdata[0];
          fire = reg_wdata[0] & ~q.trig;
        end
        HNC_OFS_HOLD: d.hold = reg_wdata[0];
        HNC_OFS_RAMP: d.ramp = reg_wdata[2:0];
        HNC_OFS_OPT: begin
          d.opt_sum = reg_wdata[HNC_OPT_SUM_BIT];
          d.opt_dith = reg_wdata[HNC_OPT_DITH_BIT];
        end
        HNC_OFS_GAIN_A: d.gain_a[7:0] = reg_wdata;
        HNC_OFS_GAIN_A + 12'h001: d.gain_a[15:8] = reg_wdata;
        HNC_OFS_GAIN_B: d.gain_b[7:0] = reg_wdata;
        HNC_OFS_GAIN_B + 12'h001: d.gain_b[15:8] = reg_wdata;
        default: begin
          // Table bytes go to the arrays; other writes are dropped
        end
      endcase
    end

    // Sync engine; a trigger that arrives while one is pending is absorbed
    d.sync_clr = 1'b0;
    case (q.sync_st)
      HNC_ST_IDLE: begin
        if (fire) begin
          case (q.sync_src)
            HNC_SYNC_NOW: d.sync_clr = 1'b1;
            HNC_SYNC_REF: d.sync_st = HNC_ST_WAIT_REF;
            HNC_SYNC_STROBE: d.sync_st = HNC_ST_WAIT_STB;
            default: d.sync_st = HNC_ST_IDLE;
          endcase
        end
      end
      HNC_ST_WAIT_REF: begin
        if (ref_rise) begin
          d.sync_clr = 1'b1;
          d.sync_st = HNC_ST_IDLE;
        end
      end
      HNC_ST_WAIT_STB: begin
        if (strobe_rise && hop_bank) begin
          d.sync_clr = 1'b1;
          d.sync_st = HNC_ST_IDLE;
        end
      end
      default: d.sync_st = HNC_ST_IDLE;
    endcase
    if (!q.run) begin
      d.sync_st = HNC_ST_IDLE;
      d.sync_clr = 1'b0;
    end

    // Frozen words keep running tones clean while software edits tables
    if (!q.hold) begin
      d.act_sel_a = q.chg_a ? q.pin_sel_a : q.sel_sw_a;
      d.act_sel_b = q.chg_b ? q.pin_sel_b : q.sel_sw_b;
      d.freq_a = freq_at(d.act_sel_a);
      d.freq_b = freq_at(d.act_sel_b);
      d.ph_a = phase_at(d.act_sel_a);
      d.ph_b = phase_at(d.act_sel_b);
    end

    sum_w = 17'(amp_a) + 17'(amp_b);
    if (sum_w > 17'sd32767) begin
      sum_sat = 16'sh7fff;
    end else if (sum_w < -17'sd32768) begin
      sum_sat = 16'sh8000;
    end else begin
      sum_sat = sum_w[15:0];
    end
    d.out_a = nco_src_a ? (q.opt_sum ? sum_sat : amp_a) : 16'sh0000;
    d.out_b = nco_src_b ? (q.opt_sum ? sum_sat : amp_b) : 16'sh0000;

    d.rvalid = reg_rd;
    if (reg_rd) begin
      if (in_freq) begin
        d.rdata = freq_mem[reg_addr[6:0]];
      end else if (in_phase) begin
        d.rdata = phase_mem[reg_addr[5:0]];
      end else begin
        case (reg_addr)
          HNC_OFS_SYNC_SRC: d.rdata = {2'b00, q.chg_b, q.chg_a, 2'b00, q.sync_src};
          HNC_OFS_SEL_A: d.rdata = {3'b000, q.sel_sw_a};
          HNC_OFS_SEL_B: d.rdata = {3'b000, q.sel_sw_b};
          HNC_OFS_BANK: d.rdata = {6'b000000, q.bank};
          HNC_OFS_RUN: d.rdata = {7'b0000000, q.run};
          HNC_OFS_TRIG: d.rdata = {7'b0000000, q.trig};
          HNC_OFS_HOLD: d.rdata = {7'b0000000, q.hold};
          HNC_OFS_RAMP: d.rdata = {5'b00000, q.ramp};
          HNC_OFS_OPT: d.rdata = {6'b000000, q.opt_dith, q.opt_sum};
          HNC_OFS_GAIN_A: d.rdata = q.gain_a[7:0];
          HNC_OFS_GAIN_A + 12'h001: d.rdata = q.gain_a[15:8];
          HNC_OFS_GAIN_B: d.rdata = q.gain_b[7:0];
          HNC_OFS_GAIN_B + 12'h001: d.rdata = q.gain_b[15:8];
          default: d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.opt_dith <= HNC_OPT_RST[HNC_OPT_DITH_BIT];
      q.gain_a <= HNC_GAIN_RST;
      q.gain_b <= HNC_GAIN_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // ****************************************
  // Oscillators
  // ****************************************
  always_comb begin
    cfg_a = '{freq: q.freq_a, phase: q.ph_a, dither_on: q.opt_dith,
              gain: gain_fac(q.gain_a, channel_dither_a), gate: q.flt.gate_a,
              ramp: q.ramp, sync_clr: q.sync_clr};
    cfg_b = '{freq: q.freq_b, phase: q.ph_b, dither_on: q.opt_dith,
              gain: gain_fac(q.gain_b, channel_dither_b), gate: q.flt.gate_b,
              ramp: q.ramp, sync_clr: q.sync_clr};
  end

  hnc_tone_core u_core_a (
    .clk(clk),
    .srst(srst | ~q.run),
    .ce(ce),
    .cfg(cfg_a),
    .amp(amp_a)
  );

  hnc_tone_core u_core_b (
    .clk(clk),
    .srst(srst | ~q.run),
    .ce(ce),
    .cfg(cfg_b),
    .amp(amp_b)
  );

  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign hop_sel_a = q.act_sel_a;
  assign hop_sel_b = q.act_sel_b;
  assign tone_a = q.out_a;
  assign tone_b = q.out_b;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_split;
    ce && q.run && strobe_rise && q.bank == HNC_BANK_SPLIT
      |=> q.pin_sel_a == {1'b0, $past(hop_val)} && q.pin_sel_b == {1'b1, $past(hop_val)};
  endproperty
  a_split: assert property (p_split) else $error("split bank hop wrong");

  property p_joint;
    ce && q.run && strobe_rise && q.bank == HNC_BANK_JOINT
      |=> q.pin_sel_a == q.pin_sel_b && q.pin_sel_a == {$past(hop_bank), $past(hop_val)};
  endproperty
  a_joint: assert property (p_joint) else $error("joint bank hop wrong");

  property p_one;
    ce && strobe_rise && q.bank == HNC_BANK_ONE && !hop_bank |=> $stable(q.pin_sel_b);
  endproperty
  a_one: assert property (p_one) else $error("wrong channel hopped");

  property p_run_off;
    ce && !q.run ##1 ce && !q.run |=> q.out_a == 16'sh0000 && q.out_b == 16'sh0000;
  endproperty
  a_run_off: assert property (p_run_off) else $error("output alive while stopped");

  property p_trig_read;
    ce && reg_wr && reg_addr == HNC_OFS_TRIG |=> q.trig == $past(reg_wdata[0]);
  endproperty
  a_trig_read: assert property (p_trig_read) else $error("trigger readback wrong");

  property p_hold;
    ce && q.hold |=> $stable(q.freq_a) && $stable(q.act_sel_a) && $stable(q.ph_b);
  endproperty
  a_hold: assert property (p_hold) else $error("update leaked through hold");

  property p_sync_now;
    ce && q.run && fire && q.sync_src == HNC_SYNC_NOW && q.sync_st == HNC_ST_IDLE |=> q.sync_clr;
  endproperty
  a_sync_now: assert property (p_sync_now) else $error("immediate sync missing");

  property p_sum;
    ce && q.opt_sum && nco_src_a && nco_src_b |=> q.out_a == q.out_b;
  endproperty
  a_sum: assert property (p_sum) else $error("summed outputs differ");

  property p_cov_hop;
    q.run && strobe_rise && q.chg_a;
  endproperty
  c_cov_hop: cover property (p_cov_hop);

  property p_cov_ref_sync;
    q.sync_st == HNC_ST_WAIT_REF ##[1:50] q.sync_clr;
  endproperty
  c_cov_ref_sync: cover property (p_cov_ref_sync);

  property p_cov_hold;
    q.run && q.hold && reg_wr && in_freq;
  endproperty
  c_cov_hold: cover property (p_cov_hold);

endmodule : hnc_hop_ctrl
`default_nettype wire

// *** sim/hnc_pin_drv.sv ***
`timescale 1ns/1ps
`default_nettype none
module hnc_pin_drv (
  input wire logic clk,
  output var hnc_pkg::hnc_pins_s pins
);
  import hnc_pkg::*;
  // ****************************************
  // Far-side pin driver
  // ****************************************
  initial pins = '0;
  task automatic hop(input logic [3:0] sel, input logic bank);
    @(negedge clk);
    pins.sel = sel;
    pins.bank = bank;
    repeat (4) @(negedge clk);
    pins.strobe = 1'b1;
    repeat (4) @(negedge clk);
    pins.strobe = 1'b0;
    // Select scrambled after the hop so stale pins never pass
    pins.sel = ~sel;
    repeat (4) @(negedge clk);
  endtask : hop
  task automatic gate(input logic on);
    @(negedge clk);
    pins.gate_a = on;
    pins.gate_b = on;
  endtask : gate
endmodule : hnc_pin_drv
`default_nettype wire

// *** sim/test_hnc_hop_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_hnc_hop_ctrl;
  import hnc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic nco_src = 1'b0;
  logic ce = 1'b1;
  logic dith = 1'b0;
  logic signed [15:0] held;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [4:0] hop_sel_a;
  logic [4:0] hop_sel_b;
  logic signed [15:0] tone_a;
  logic signed [15:0] tone_b;
  logic same;
  logic nz;
  hnc_pins_s pins;
  int num_errors = 0;
  int checks = 0;
  logic [2:0][1:0] codes = {2'h2, 2'h1, 2'h0};
  logic [2:0][3:0] sels = {4'h9, 4'h3, 4'h5};
  logic [2:0] banks = 3'b101;
  logic [2:0][4:0] exp_a = {5'h03, 5'h03, 5'h05};
  logic [2:0][4:0] exp_b = {5'h19, 5'h03, 5'h15};

  always #20 clk = ~clk;

  hnc_pin_drv hnc_pin_drv_i (.clk(clk), .pins(pins));
  hnc_hop_ctrl hnc_hop_ctrl_i (
    .clk(clk), .srst(srst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pins(pins), .channel_dither_a(dith),
    .channel_dither_b(dith), .nco_src_a(nco_src), .nco_src_b(nco_src),
    .hop_sel_a(hop_sel_a), .hop_sel_b(hop_sel_b), .tone_a(tone_a), .tone_b(tone_b)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(16'(reg_rvalid), 16'h0001);
    chk(16'(reg_rdata), 16'(exp));
  endtask : rd
  // Frequency word sent and read back as four little-endian bytes
  task automatic freq(input int n, input logic [31:0] w);
    for (int i = 0; i < 4; i++) wr(12'(HNC_OFS_FREQ + 12'(4 * n + i)), w[8*i+:8]);
    for (int i = 0; i < 4; i++) rd(12'(HNC_OFS_FREQ + 12'(4 * n + i)), w[8*i+:8]);
  endtask : freq
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    rd(HNC_OFS_OPT, 8'h02);
    rd(HNC_OFS_GAIN_A, 8'h03);
    rd(12'(HNC_OFS_GAIN_A + 12'h1), 8'h00);
    rd(HNC_OFS_GAIN_B, 8'h03);
    rd(HNC_OFS_RUN, 8'h00);
    rd(12'h500, 8'h00);
    // Tables filled while stopped, so no hold is needed yet
    freq(15, 32'hdeadbeef);
    freq(0, 32'h04000000);
    freq(16, 32'h04000000);
    wr(HNC_OFS_RAMP, 8'hff);
    rd(HNC_OFS_RAMP, 8'h07);
    wr(HNC_OFS_RAMP, 8'h00);
    wr(HNC_OFS_RUN, 8'hff);
    rd(HNC_OFS_RUN, 8'h01);
    wr(HNC_OFS_TRIG, 8'h01);
    rd(HNC_OFS_TRIG, 8'h01);
    // Pin hops in the split, joint and one bank setups; bank code only changes while stopped
    wr(HNC_OFS_SYNC_SRC, 8'h30);
    for (int i = 0; i < 3; i++) begin
      wr(HNC_OFS_RUN, 8'h00);
      wr(HNC_OFS_BANK, {6'h00, codes[i]});
      wr(HNC_OFS_RUN, 8'h01);
      hnc_pin_drv_i.hop(sels[i], banks[i]);
      chk(16'(hop_sel_a), 16'(exp_a[i]));
      chk(16'(hop_sel_b), 16'(exp_b[i]));
    end
    wr(HNC_OFS_SYNC_SRC, 8'h00);
    wr(HNC_OFS_HOLD, 8'h01);
    wr(HNC_OFS_SEL_A, 8'h0a);
    wr(HNC_OFS_SEL_B, 8'h10);
    wr(HNC_OFS_HOLD, 8'h00);
    repeat (6) @(negedge clk);
    chk(16'(hop_sel_a), 16'h000a);
    chk(16'(hop_sel_b), 16'h0010);
    wr(HNC_OFS_HOLD, 8'h01);
    wr(HNC_OFS_SEL_A, 8'h00);
    repeat (6) @(negedge clk);
    chk(16'(hop_sel_a), 16'h000a);
    wr(HNC_OFS_HOLD, 8'h00);
    repeat (6) @(negedge clk);
    chk(16'(hop_sel_a), 16'h0000);
    nco_src = 1'b1;
    hnc_pin_drv_i.gate(1'b1);
    nz = 1'b0;
    repeat (100) @(negedge clk) if (tone_a !== 16'sh0000) nz = 1'b1;
    chk(16'(nz), 16'h0001);
    // Clock enable low must freeze a moving tone
    @(negedge clk);
    ce = 1'b0;
    held = tone_a;
    repeat (5) @(negedge clk);
    chk(tone_a, held);
    ce = 1'b1;
    // Backoff plus dither backoff passes unity: gain saturates at zero
    hnc_pin_drv_i.gate(1'b0);
    wr(HNC_OFS_RUN, 8'h00);
    dith = 1'b1;
    wr(HNC_OFS_GAIN_A, 8'hff);
    wr(12'(HNC_OFS_GAIN_A + 12'h1), 8'hff);
    wr(HNC_OFS_RUN, 8'h01);
    hnc_pin_drv_i.gate(1'b1);
    nz = 1'b0;
    repeat (100) @(negedge clk) if (tone_a !== 16'sh0000) nz = 1'b1;
    chk(16'(nz), 16'h0000);
    hnc_pin_drv_i.gate(1'b0);
    wr(HNC_OFS_OPT, 8'h03);
    hnc_pin_drv_i.gate(1'b1);
    repeat (10) @(negedge clk);
    same = 1'b1;
    nz = 1'b0;
    // Channel A's own tone is silent, so any output on A comes from the sum
    repeat (60) @(negedge clk) begin
      if (tone_a !== tone_b) same = 1'b0;
      if (tone_a !== 16'sh0000) nz = 1'b1;
    end
    chk(16'(same), 16'h0001);
    chk(16'(nz), 16'h0001);
    wr(HNC_OFS_RUN, 8'h00);
    repeat (6) @(negedge clk);
    chk(tone_a, 16'h0000);
    end_of_test();
  end
endmodule : test_hnc_hop_ctrl
`default_nettype wire
